// file: hw/lpcff_pkg.sv
package lpcff_pkg;
	// ---------------------------------------------------------------
	// start codes and cycle fields
	// ---------------------------------------------------------------
	localparam logic [3:0] START_MEM = 4'h0;
	localparam logic [3:0] START_FW_RD = 4'hd;
	localparam logic [3:0] START_FW_WR = 4'he;
	localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] LAD_ONES = 4'hf;
	localparam logic [3:0] BOOT_ID = 4'h0;
	localparam int FW_ADDR_NIBBLES = 7;
	localparam int MEM_ADDR_NIBBLES = 8;
	localparam int ADDR_W = 19;
	// ---------------------------------------------------------------
	// memory map
	// ---------------------------------------------------------------
	localparam logic [2:0] TOP_BLOCK = 3'h7;
	localparam int TOP_BLK_LSB = 16;
	localparam int COL_LSB = 11;
	localparam int ROW_W = 11;
	localparam int COL_W = 8;
	localparam logic [18:0] ID_MFR_ADDR = 19'h00000;
	localparam logic [18:0] ID_DEV_ADDR = 19'h00001;
	localparam logic [18:0] GPI_ADDR = 19'h7ff00;
	localparam logic [7:0] WRITE_CMD_ID_ON = 8'h90;
	localparam logic [7:0] WRITE_CMD_ID_OFF = 8'hf0;
	localparam logic [7:0] WRITE_CMD_CHIP_ERASE = 8'h10;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int WRITE_BUSY_US = 20;
	localparam int WRITE_BUSY_CYC = WRITE_BUSY_US * CLK_MHZ;
	localparam int RESET_LATENCY_US = 10;
	localparam int RESET_LATENCY_CYC = RESET_LATENCY_US * CLK_MHZ;
	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_DIR, ST_ID_SELECT_FIELD, ST_ADDR, ST_SIZE, ST_WDATA_LO, ST_WDATA_HI,
		ST_TAR0, ST_TAR1, ST_SYNC, ST_RDATA_LO, ST_RDATA_HI, ST_HTAR0, ST_HTAR1
	} lpcff_state_t;
endpackage

// file: hw/lpcff_front_end.sv
`timescale 1ns/1ps
// Summary of operation
// - frame low marks a new cycle start
// - frame low mid cycle aborts transaction
// - strap high parallel mode, low serial
// - either reset input resets device equally
// - reset during read releases bus lines
// - reset aborts running program or erase
// - reset during write adds recovery latency
// - general inputs readable as register in serial mode only
// - top guard low blocks top block byte writes; chip erase is not gated by it
// - write guard low blocks byte writes to other blocks; chip erase is not gated by it
// - column bits 18-11, row bits 10-0
// - output gate enables data, strobe writes
// - standby when frame high, idle and no write busy
// - last nibble before frame rise starts
// - start codes 0000, 1101, 1110 only
// - generic cycle direction from second field
// - single byte transfers only
// - chip erase only in parallel mode
// - id codes at relative addresses 0,1
// - firmware cycle answers only matching id
// - firmware address seven nibbles msb first
// - bus fields sampled on rising edges
module lpcff_front_end import lpcff_pkg::*; #(
	parameter int BUSY_CYCLES = WRITE_BUSY_CYC,
	parameter int RECOVER_CYCLES = RESET_LATENCY_CYC,
	parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3c // arbitrary value
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire logic bus_clock, // host bus clock, sampled
	input wire logic frame_n, // cycle frame from host
	input wire logic [3:0] lad_in, // bus nibble in
	output logic [3:0] lad_out, // bus nibble out
	output logic lad_oe, // bus drive enable
	input wire logic reset_pin_n, // first reset pin
	input wire logic second_reset_n, // second reset pin
	input wire logic mode_strap, // high selects parallel mode
	input wire logic [3:0] strap_select, // id strap
	input wire logic [4:0] general_inputs, // general inputs
	input wire logic top_block_guard_n, // top block guard
	input wire logic write_guard_n, // other blocks guard
	input wire logic row_col_sel, // high row, low column
	input wire logic [10:0] pp_addr, // shared address pins
	input wire logic [7:0] dq_in, // parallel data in
	output logic [7:0] dq_out, // parallel data out
	output logic dq_oe, // parallel data drive enable
	input wire logic output_gate_n, // parallel output gate
	input wire logic write_strobe_n, // parallel write strobe
	output logic [18:0] mem_addr, // array address
	input wire logic [7:0] mem_rdata, // array read data
	output logic [7:0] mem_wdata, // array write data
	output logic mem_write, // write byte pulse
	output logic mem_chip_erase, // chip erase pulse
	output logic mem_abort, // abort running write
	output logic write_busy, // program or erase running
	output logic standby, // standby indication
	output logic protect_reject // pulse on refused write
);
	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (BUSY_CYCLES < 1) begin : g_busy_bad
		$error("busy count must be at least one");
	end
	if (RECOVER_CYCLES < 1) begin : g_recover_bad
		$error("recovery count must be at least one");
	end
	if (ADDR_W != COL_LSB + COL_W) begin : g_map_bad
		$error("column field must end at the top address bit");
	end
	if (ROW_W != COL_LSB) begin : g_row_bad
		$error("row field must meet the column field");
	end
	if (FW_ADDR_NIBBLES > 8 || MEM_ADDR_NIBBLES > 8) begin : g_nib_bad
		$error("address nibble counts must fit the shift register");
	end
	if (TOP_BLK_LSB >= ADDR_W) begin : g_top_bad
		$error("top block field must lie inside the address");
	end

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	localparam int SW = 30;
	logic [SW-1:0] s1_reg, s2_reg, s3_reg;
	// order here fixes the tap indices below
	wire [SW-1:0] raw_in = {bus_clock, frame_n, lad_in, reset_pin_n, second_reset_n,
		mode_strap, general_inputs, top_block_guard_n, write_guard_n, row_col_sel,
		output_gate_n, write_strobe_n, dq_in, 3'h0};
	logic [SW-1:0] filt_reg;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_reg <= {SW{1'b1}};
			s2_reg <= {SW{1'b1}};
			s3_reg <= {SW{1'b1}};
			filt_reg <= {SW{1'b1}};
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < SW; i++)
				if (s2_reg[i] == s3_reg[i])
					filt_reg[i] <= s2_reg[i];
		end
	end

	// ---------------------------------------------------------------
	// synchronised taps
	// ---------------------------------------------------------------
	wire bus_clock_s = filt_reg[29];
	wire frame_s_n = filt_reg[28];
	wire [3:0] lad_s = filt_reg[27:24];
	wire rst_pins_low = !filt_reg[23] || !filt_reg[22];
	wire [4:0] gpi_s = filt_reg[20:16];
	wire tbl_s_n = filt_reg[15];
	wire wp_s_n = filt_reg[14];
	wire rc_s = filt_reg[13];
	wire oe_s_n = filt_reg[12];
	wire we_s_n = filt_reg[11];
	wire [7:0] dq_s = filt_reg[10:3];

	// strap caught once the synchronisers hold the real pin level;
	// the filter resets to ones, so an early capture would force parallel mode
	localparam int STRAP_SETTLE = 6;
	logic [2:0] strap_wait_reg;
	logic pp_mode_reg, strap_taken_reg;
	wire strap_settled = strap_wait_reg == 3'(STRAP_SETTLE);
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			strap_wait_reg <= 3'h0;
			pp_mode_reg <= 1'b0;
			strap_taken_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			if (strap_settled) begin
				pp_mode_reg <= filt_reg[21];
				strap_taken_reg <= 1'b1;
			end else begin
				strap_wait_reg <= strap_wait_reg + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// bus clock edge enable and reset handling
	// ---------------------------------------------------------------
	logic bus_clock_d_reg;
	always_ff @(posedge mclk) begin
		if (!rst_n)
			bus_clock_d_reg <= 1'b1; // filter resets high: no false edge
		else
			bus_clock_d_reg <= bus_clock_s;
	end
	wire bus_clock_rise = bus_clock_s && !bus_clock_d_reg;

	logic [31:0] busy_cnt_reg, recover_cnt_reg;
	wire busy_now = busy_cnt_reg != 32'h0;
	wire recovering = recover_cnt_reg != 32'h0;
	wire dev_reset = rst_pins_low || recovering || !strap_taken_reg;
	wire lpc_en = strap_taken_reg && !pp_mode_reg;

	// ---------------------------------------------------------------
	// serial cycle engine
	// ---------------------------------------------------------------
	lpcff_state_t state_reg, state_next;
	logic is_fw_reg, is_write_reg, selected_reg;
	logic [2:0] nib_cnt_reg;
	logic [31:0] addr_sh_reg;
	logic [7:0] wdata_reg, rdata_reg;
	logic [3:0] start_reg;

	wire frame_low = !frame_s_n;
	wire start_ok = start_reg == START_MEM || start_reg == START_FW_RD ||
		start_reg == START_FW_WR;
	// the field right after the frame rises is direction or id select
	wire gen_start = start_reg == START_MEM;
	wire second_write = gen_start ? lad_s[1] : start_reg == START_FW_WR;
	wire second_select = gen_start || lad_s == strap_select;
	wire [2:0] last_nib = is_fw_reg ? 3'(FW_ADDR_NIBBLES - 1) : 3'(MEM_ADDR_NIBBLES - 1);
	wire [18:0] cyc_addr = addr_sh_reg[18:0];
	wire addr_is_gpi = cyc_addr == GPI_ADDR;
	wire rd_cycle_drive = selected_reg && !is_write_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: if (frame_low) state_next = ST_START;
			ST_START: begin
				// frame rise: this same rise already carries the second field
				if (!frame_low && start_ok)
					state_next = ST_ADDR;
				else if (!frame_low)
					state_next = ST_IDLE;
			end
			ST_DIR: state_next = ST_ADDR;
			ST_ID_SELECT_FIELD: state_next = ST_ADDR;
			ST_ADDR: if (nib_cnt_reg == last_nib) state_next = is_fw_reg ? ST_SIZE :
				(is_write_reg ? ST_WDATA_LO : ST_TAR0);
			ST_SIZE: state_next = is_write_reg ? ST_WDATA_LO : ST_TAR0;
			ST_WDATA_LO: state_next = ST_WDATA_HI;
			ST_WDATA_HI: state_next = ST_TAR0;
			ST_TAR0: state_next = ST_TAR1;
			ST_TAR1: state_next = ST_SYNC;
			ST_SYNC: state_next = is_write_reg ? ST_HTAR0 : ST_RDATA_LO;
			ST_RDATA_LO: state_next = ST_RDATA_HI;
			ST_RDATA_HI: state_next = ST_HTAR0;
			ST_HTAR0: state_next = ST_HTAR1;
			ST_HTAR1: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (frame_low && state_reg != ST_IDLE && state_reg != ST_START)
			state_next = ST_START;
	end

	// ---------------------------------------------------------------
	// byte write request from either port
	// ---------------------------------------------------------------
	logic wr_req;
	logic [18:0] wr_addr;
	logic [7:0] wr_byte;
	logic id_mode_reg;
	logic [18:0] pp_addr_reg;
	logic we_d_reg;
	wire pp_we_rise = pp_mode_reg && we_s_n && !we_d_reg;
	wire lpc_wr_done = bus_clock_rise && state_reg == ST_TAR0 && is_write_reg && selected_reg;
	assign wr_req = lpc_wr_done || pp_we_rise;
	assign wr_addr = pp_mode_reg ? pp_addr_reg : cyc_addr;
	assign wr_byte = pp_mode_reg ? dq_s : wdata_reg;
	wire top_hit = wr_addr[18:TOP_BLK_LSB] == TOP_BLOCK;
	wire guard_block = top_hit ? !tbl_s_n : !wp_s_n;
	wire is_cmd = wr_byte == WRITE_CMD_ID_ON || wr_byte == WRITE_CMD_ID_OFF;
	wire chip_erase_req = pp_mode_reg && wr_byte == WRITE_CMD_CHIP_ERASE;
	wire array_op = !is_cmd && !busy_now;
	// a refused write never starts the busy timer
	wire write_go = wr_req && array_op && !guard_block;
	wire [7:0] id_byte = wr_addr[0] ? DEV_CODE : MFR_CODE;
	wire [7:0] read_src = addr_is_gpi ? {3'h0, gpi_s} :
		(id_mode_reg ? id_byte : mem_rdata);

	always_ff @(posedge mclk) begin
		if (!rst_n || dev_reset || !lpc_en) begin
			state_reg <= ST_IDLE;
			selected_reg <= 1'b0;
			is_fw_reg <= 1'b0;
			is_write_reg <= 1'b0;
			nib_cnt_reg <= 3'h0;
			addr_sh_reg <= 32'h0;
			wdata_reg <= 8'h0;
			rdata_reg <= 8'h0;
			start_reg <= 4'h0;
		end else if (bus_clock_rise) begin
			state_reg <= state_next;
			if (frame_low)
				start_reg <= lad_s;
			case (state_reg)
				ST_START: begin
					if (!frame_low) begin
						is_fw_reg <= !gen_start;
						is_write_reg <= second_write;
						selected_reg <= second_select;
						nib_cnt_reg <= 3'h0;
						addr_sh_reg <= 32'h0;
					end
				end
				ST_DIR: ;
				ST_ID_SELECT_FIELD: ;
				ST_ADDR: begin
					addr_sh_reg <= {addr_sh_reg[27:0], lad_s};
					nib_cnt_reg <= nib_cnt_reg + 3'h1;
				end
				ST_SIZE: if (lad_s != SIZE_ONE_BYTE) selected_reg <= 1'b0;
				ST_WDATA_LO: wdata_reg[3:0] <= lad_s;
				ST_WDATA_HI: wdata_reg[7:4] <= lad_s;
				ST_TAR1: rdata_reg <= read_src;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// parallel port, id mode, write engine
	// ---------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n || dev_reset) begin
			pp_addr_reg <= 19'h0;
			we_d_reg <= 1'b1;
			id_mode_reg <= 1'b0;
		end else begin
			we_d_reg <= we_s_n;
			if (pp_mode_reg && rc_s)
				pp_addr_reg[ROW_W-1:0] <= pp_addr;
			else if (pp_mode_reg)
				pp_addr_reg[ADDR_W-1:COL_LSB] <= pp_addr[COL_W-1:0];
			if (wr_req && wr_byte == WRITE_CMD_ID_ON)
				id_mode_reg <= 1'b1;
			else if (wr_req && wr_byte == WRITE_CMD_ID_OFF)
				id_mode_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_cnt_reg <= 32'h0;
			recover_cnt_reg <= 32'h0;
			mem_abort <= 1'b0;
		end else if (rst_pins_low) begin
			// the cut write leaves its bytes undefined in the array
			busy_cnt_reg <= 32'h0;
			mem_abort <= busy_now;
			if (busy_now)
				recover_cnt_reg <= 32'(RECOVER_CYCLES);
		end else begin
			mem_abort <= 1'b0;
			if (recovering)
				recover_cnt_reg <= recover_cnt_reg - 32'h1;
			if (write_go)
				busy_cnt_reg <= 32'(BUSY_CYCLES);
			else if (busy_now)
				busy_cnt_reg <= busy_cnt_reg - 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	// reads drive sync, data and turnaround; writes only sync and turnaround
	wire drive_state = state_reg inside {ST_SYNC, ST_RDATA_LO, ST_RDATA_HI, ST_HTAR0};
	wire write_drive = state_reg == ST_SYNC || state_reg == ST_HTAR0;
	wire cycle_drive = rd_cycle_drive || (selected_reg && write_drive);
	wire drive_lad = lpc_en && !dev_reset && cycle_drive && drive_state;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lad_out <= LAD_ONES;
			lad_oe <= 1'b0;
			dq_out <= 8'h0;
			dq_oe <= 1'b0;
			mem_addr <= 19'h0;
			mem_wdata <= 8'h0;
			mem_write <= 1'b0;
			mem_chip_erase <= 1'b0;
			write_busy <= 1'b0;
			standby <= 1'b0;
			protect_reject <= 1'b0;
		end else begin
			// each nibble stands until the next detected bus clock rise
			case (state_reg)
				ST_SYNC: lad_out <= SYNC_READY;
				ST_RDATA_LO: lad_out <= rdata_reg[3:0];
				ST_RDATA_HI: lad_out <= rdata_reg[7:4];
				default: lad_out <= LAD_ONES;
			endcase
			lad_oe <= drive_lad && !rst_pins_low;
			dq_out <= read_src;
			dq_oe <= pp_mode_reg && !oe_s_n && !dev_reset;
			mem_addr <= wr_addr;
			mem_wdata <= wr_byte;
			mem_write <= write_go && !chip_erase_req && !dev_reset;
			mem_chip_erase <= wr_req && array_op && chip_erase_req && !dev_reset;
			protect_reject <= wr_req && array_op && guard_block;
			write_busy <= busy_now;
			standby <= frame_s_n && state_reg == ST_IDLE && !busy_now;
		end
	end
endmodule

// file: verification/lpcff_front_end_props.sv
`timescale 1ns/1ps
module lpcff_front_end_props import lpcff_pkg::*; (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic frame_n, // frame
	input wire logic lad_oe, // bus drive
	input wire logic reset_pin_n, // pin one
	input wire logic second_reset_n, // pin two
	input wire logic mode_strap, // mode
	input wire logic top_block_guard_n, // guard
	input wire logic write_guard_n, // guard
	input wire logic output_gate_n, // gate
	input wire logic dq_oe, // drive
	input wire logic [18:0] mem_addr, // address
	input wire logic mem_write, // write
	input wire logic write_busy, // busy
	input wire logic standby // standby
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// spans of 8 cover the pin synchronisers plus the output register
	abort_release_a: assert property (!frame_n [*8] |-> !lad_oe)
		else $error("bus driven under frame");
	pin_release_a: assert property (!reset_pin_n [*8] |-> !lad_oe)
		else $error("bus driven in reset");
	second_release_a: assert property (!second_reset_n [*8] |-> !lad_oe)
		else $error("bus driven in reset");
	parallel_quiet_a: assert property (mode_strap && $past(mode_strap, 8) |-> !lad_oe)
		else $error("bus driven in parallel mode");
	top_guard_a: assert property (mem_write && mem_addr[18:16] == TOP_BLOCK
		|-> top_block_guard_n) else $error("guarded top write");
	other_guard_a: assert property (mem_write && mem_addr[18:16] != TOP_BLOCK
		|-> write_guard_n) else $error("guarded write");
	gate_release_a: assert property (output_gate_n [*8] |-> !dq_oe)
		else $error("data driven without gate");
	busy_awake_a: assert property (write_busy [*3] |-> !standby)
		else $error("standby while busy");
endmodule
bind lpcff_front_end lpcff_front_end_props lpcff_front_end_props_inst (.mclk, .rst_n, .frame_n,
	.lad_oe, .reset_pin_n, .second_reset_n, .mode_strap, .top_block_guard_n, .write_guard_n,
	.output_gate_n, .dq_oe, .mem_addr, .mem_write, .write_busy, .standby);

// file: verification/lpcff_host_model.sv
`timescale 1ns/1ps
module lpcff_host_model import lpcff_pkg::*; (
	input wire logic mclk, // system clock
	output logic bus_clock, // bus clock
	output logic frame_n, // frame
	output logic [3:0] lad_in, // resolved nibble
	input wire logic [3:0] lad_out, // device nibble
	input wire logic lad_oe // device drive
);
	logic [3:0] host_lad_reg = LAD_ONES;
	logic host_oe_reg = 1'b0;
	// nobody driving: pull-ups give ones
	assign lad_in = lad_oe ? lad_out : (host_oe_reg ? host_lad_reg : LAD_ONES);
	initial begin
		bus_clock = 1'b0;
		frame_n = 1'b1;
	end
	// clock stands still between fields; sample taken at the rise
	task automatic field(input logic oe, input logic [3:0] nib, input logic fr,
		output logic [3:0] seen);
		@(posedge mclk);
		host_oe_reg <= oe;
		host_lad_reg <= nib;
		frame_n <= fr;
		repeat (6) @(posedge mclk);
		bus_clock <= 1'b1;
		seen = lad_in;
		repeat (6) @(posedge mclk);
		bus_clock <= 1'b0;
	endtask
	task automatic cycle(input logic [3:0] start, input logic [3:0] second,
		input logic [31:0] addr, input int nibs, input logic sized, input logic wr,
		input logic [7:0] data, output logic [7:0] rd, output logic hit);
		logic [3:0] s;
		int k;
		k = 0;
		hit = 1'b0;
		rd = 8'h00;
		field(1'b1, start, 1'b0, s);
		field(1'b1, second, 1'b1, s);
		for (int i = nibs - 1; i >= 0; i--) begin
			field(1'b1, addr[4*i+:4], 1'b1, s);
		end
		if (sized) begin
			field(1'b1, SIZE_ONE_BYTE, 1'b1, s);
		end
		if (wr) begin
			field(1'b1, data[3:0], 1'b1, s);
			field(1'b1, data[7:4], 1'b1, s);
		end
		field(1'b1, LAD_ONES, 1'b1, s);
		for (int i = 0; i < 7; i++) begin
			field(1'b0, LAD_ONES, 1'b1, s);
			if (hit && k < 2) begin
				rd[4*k+:4] = s;
				k++;
			end else if (!hit && s == SYNC_READY) begin
				hit = 1'b1;
			end
		end
	endtask
endmodule

// file: verification/lpcff_front_end_bench.sv
`timescale 1ns/1ps
module lpcff_front_end_bench import lpcff_pkg::*; ;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic bus_clock, frame_n, lad_oe, dq_oe, h, mem_write, mem_chip_erase, mem_abort;
	logic write_busy, standby, protect_reject, reset_pin_n, second_reset_n, mode_strap;
	logic top_block_guard_n, write_guard_n, row_col_sel, output_gate_n;
	logic [3:0] lad_in, lad_out, s;
	logic [4:0] general_inputs;
	logic [10:0] pp_addr;
	logic [7:0] dq_out, mem_rdata, mem_wdata, d, wr_data, w0, r0, a0;
	logic [18:0] mem_addr, wr_addr;
	logic [7:0] wr_cnt = 8'h00, rej_cnt = 8'h00, abort_cnt = 8'h00, erase_cnt = 8'h00;
	logic [7:0] dq_in;
	logic write_strobe_n;
	logic [15:0] bad_codes = 16'h15cf;
	int bad_count = 0, total_checks = 0;
	always #5 mclk = ~mclk;
	assign mem_rdata = mem_addr[7:0] ^ 8'ha5;
	lpcff_front_end #(.BUSY_CYCLES(400), .RECOVER_CYCLES(300)) lpcff_front_end_inst (.mclk,
		.rst_n, .bus_clock, .frame_n, .lad_in, .lad_out, .lad_oe, .reset_pin_n, .second_reset_n,
		.mode_strap, .strap_select(BOOT_ID), .general_inputs, .top_block_guard_n, .write_guard_n,
		.row_col_sel, .pp_addr, .dq_in, .dq_out, .dq_oe, .output_gate_n,
		.write_strobe_n, .mem_addr, .mem_rdata, .mem_wdata, .mem_write, .mem_chip_erase,
		.mem_abort, .write_busy, .standby, .protect_reject); // boot strap id
	lpcff_host_model lpcff_host_model_inst (.mclk, .bus_clock, .frame_n, .lad_in, .lad_out,
		.lad_oe);
	always @(posedge mclk) begin
		if (mem_write === 1'b1) begin
			wr_cnt <= wr_cnt + 8'h01;
			wr_addr <= mem_addr;
			wr_data <= mem_wdata;
		end
		if (protect_reject === 1'b1) rej_cnt <= rej_cnt + 8'h01;
		if (mem_abort === 1'b1) abort_cnt <= abort_cnt + 8'h01;
		if (mem_chip_erase === 1'b1) erase_cnt <= erase_cnt + 8'h01;
	end
	task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [3:0] code, input logic [3:0] id, input logic [31:0] a);
		lpcff_host_model_inst.cycle(code, id, a, 7, 1'b1, 1'b0, 8'h00, d, h);
	endtask
	// guards settle well before the cycle and stay put through the busy time
	task automatic wr(input logic tbl, input logic wp, input logic [31:0] a);
		top_block_guard_n <= tbl;
		write_guard_n <= wp;
		w0 = wr_cnt;
		r0 = rej_cnt;
		repeat (8) @(posedge mclk);
		lpcff_host_model_inst.cycle(START_FW_WR, BOOT_ID, a, 7, 1'b1, 1'b1, 8'h3c, d, h);
	endtask
	task automatic rst(input logic strap);
		rst_n <= 1'b0;
		mode_strap <= strap;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		{reset_pin_n, second_reset_n, top_block_guard_n, write_guard_n} = 4'hf;
		{mode_strap, row_col_sel, output_gate_n, pp_addr} = 14'h0800;
		write_strobe_n = 1'b1;
		dq_in = 8'h00;
		general_inputs = 5'h15; // held steady across reads
		rst(1'b0);
		rd(START_FW_RD, BOOT_ID, GPI_ADDR);
		chk("gpi", 19'h15, 19'(d));
		rd(START_FW_RD, 4'h1, GPI_ADDR);
		chk("id_select_field miss", 19'h0, 19'(h));
		rd(START_FW_RD, BOOT_ID, 32'h0012345);
		chk("fw data", 19'he0, 19'(d));
		lpcff_host_model_inst.cycle(START_MEM, 4'h4, 32'hfff12345, 8, 1'b0, 1'b0, 8'h00, d, h);
		chk("mem data", 19'he0, 19'(d));
		for (int i = 0; i < 4; i++) begin
			rd(bad_codes[4*i+:4], BOOT_ID, GPI_ADDR);
			chk("bad start", 19'h0, 19'(h));
		end
		lpcff_host_model_inst.field(1'b1, START_FW_RD, 1'b0, s);
		lpcff_host_model_inst.field(1'b1, BOOT_ID, 1'b1, s);
		lpcff_host_model_inst.field(1'b1, LAD_ONES, 1'b0, s);
		rd(START_FW_RD, BOOT_ID, GPI_ADDR);
		chk("after abort", 19'h15, 19'(d));
		$display("serial reads done");
		for (int i = 0; i < 4; i++) begin
			wr(i != 1, i != 2, (i < 2) ? 32'h0070010 : 32'h0010010);
			for (int j = 0; j < 600 && write_busy !== 1'b0; j++) @(posedge mclk);
			chk("written", 19'(i == 0 || i == 3), 19'(wr_cnt - w0));
			chk("refused", 19'(i == 1 || i == 2), 19'(rej_cnt - r0));
		end
		chk("write addr", 19'h10010, wr_addr);
		chk("write data", 19'h3c, 19'(wr_data));
		$display("guard writes done");
		for (int p = 0; p < 2; p++) begin
			a0 = abort_cnt;
			wr(1'b1, 1'b1, 32'h0020020);
			{reset_pin_n, second_reset_n} <= (p == 0) ? 2'b01 : 2'b10;
			repeat (10) @(posedge mclk);
			{reset_pin_n, second_reset_n} <= 2'b11;
			chk("aborted", 19'h1, 19'(abort_cnt != a0));
			rd(START_FW_RD, BOOT_ID, GPI_ADDR);
			chk("recovering", 19'h0, 19'(h));
			repeat (300) @(posedge mclk);
			rd(START_FW_RD, BOOT_ID, GPI_ADDR);
			chk("recovered", 19'h15, 19'(d));
		end
		$display("reset pins done");
		rst(1'b1);
		rd(START_FW_RD, BOOT_ID, GPI_ADDR);
		chk("serial ignored", 19'h0, 19'(h));
		pp_addr <= 11'h0b6;
		repeat (8) @(posedge mclk);
		row_col_sel <= 1'b1;
		repeat (8) @(posedge mclk);
		pp_addr <= 11'h123;
		repeat (8) @(posedge mclk);
		output_gate_n <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("pp addr", 19'h5b123, mem_addr);
		chk("pp data", 19'h86, 19'(dq_out));
		chk("pp drive", 19'h1, 19'(dq_oe));
		dq_in <= 8'h5e;
		write_strobe_n <= 1'b0;
		repeat (8) @(posedge mclk);
		write_strobe_n <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("pp write addr", 19'h5b123, wr_addr);
		chk("pp write data", 19'h5e, 19'(wr_data));
		repeat (450) @(posedge mclk);
		dq_in <= WRITE_CMD_CHIP_ERASE;
		write_strobe_n <= 1'b0;
		repeat (8) @(posedge mclk);
		write_strobe_n <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("chip erase", 19'h1, 19'(erase_cnt));
		$display("parallel done");
		finish_test();
	end
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		finish_test();
	end
endmodule
